/* bus_host_model.sv */
`timescale 1ns/100ps
// two-wire bus host; moves its lines only at falling clock edges
module bus_host_model (
  input  wire logic clk,      // system clock
  input  wire logic sda_line, // resolved data wire
  output logic      scl,      // serial clock, idle high
  output logic      sda_low   // host pulls data low
);
  // both lines released at time zero, pull-ups hold them high
  initial begin
    scl     = 1'h1;
    sda_low = 1'h0;
  end

  // one serial clock phase, four system clocks
  task automatic half;
    repeat (4) @(negedge clk);
  endtask

  // start or repeated start: data falls while clock is high
  task automatic bus_start;
    sda_low = 1'h0;
    half;
    scl = 1'h1;
    half;
    sda_low = 1'h1;
    half;
    scl = 1'h0;
    half;
  endtask

  // stop: data rises while clock is high
  task automatic bus_stop;
    sda_low = 1'h1;
    half;
    scl = 1'h1;
    half;
    sda_low = 1'h0;
    half;
  endtask

  // one bit: data set while clock low, held over the rising edge
  task automatic put_bit(input logic b);
    sda_low = ~b;
    half;
    scl = 1'h1;
    half;
    scl = 1'h0;
    half;
  endtask

  // address byte carries the direction bit in its lsb
  task automatic send_byte(input logic [7:0] v, output logic ack_n);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    sda_low = 1'h0;
    half;
    scl = 1'h1;
    half;
    ack_n = sda_line;
    scl = 1'h0;
    half;
  endtask

  // read byte from the slave, then acknowledge (1) or not (0)
  task automatic recv_byte(input logic ack_it, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sda_low = 1'h0;
      half;
      scl = 1'h1;
      half;
      v[i] = sda_line;
      scl = 1'h0;
      half;
    end
    put_bit(~ack_it);
    sda_low = 1'h0;
  endtask
endmodule

/* dual_supply_level_select.sv */
`timescale 1ns/100ps
module dual_supply_level_select
  import level_select_pkg::*;
(
  input  wire logic                                clk,           // 125 MHz clock
  input  wire logic                                arst_n,        // async reset, low
  input  wire logic                                scl_i,         // serial clock level
  input  wire logic                                sda_i,         // serial data level
  output logic                                     sda_o,         // data out, always 0
  output logic                                     sda_oe,        // pull data line low
  input  wire logic                                addr_strap,    // address strap pin
  output logic [level_select_pkg::CTRL_W-1:0]      level_control, // control register
  output logic                                     supply_en_a,   // channel a on
  output logic                                     range_high_a,  // channel a 18 V
  output logic [1:0]                               level_step_a,  // channel a step
  output logic [level_select_pkg::MV_W-1:0]        nominal_mv_a,  // channel a mV
  output logic                                     code_bad_a,    // channel a bad code
  output logic                                     supply_en_b,   // channel b on
  output logic                                     range_high_b,  // channel b 18 V
  output logic [1:0]                               level_step_b,  // channel b step
  output logic [level_select_pkg::MV_W-1:0]        nominal_mv_b,  // channel b mV
  output logic                                     code_bad_b     // channel b bad code
);
  import level_select_pkg::*;

  slave_state_t        state_ff;
  logic                scl_q_ff;
  logic                sda_q_ff;
  logic [3:0]          bit_cnt_ff;
  logic [7:0]          shift_ff;
  logic [7:0]          tx_ff;
  logic                rw_ff;
  logic                nack_ff;
  logic                sda_oe_ff;
  logic [CTRL_W-1:0]   ctrl_ff;
  logic [CHANNELS-1:0] en_ff;
  logic [CHANNELS-1:0] rng_ff;
  logic [CHANNELS-1:0] bad_ff;
  logic [1:0]          step_ff [CHANNELS];
  logic [MV_W-1:0]     mv_ff [CHANNELS];
  logic                scl_rise;
  logic                scl_fall;
  logic                start_seen;
  logic                stop_seen;
  logic                byte_done;
  logic [6:0]          own_addr;
  logic                addr_hit;

  // line events from the previous sample
  assign scl_rise   = scl_i & ~scl_q_ff;
  assign scl_fall   = ~scl_i & scl_q_ff;
  assign start_seen = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_seen  = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign byte_done  = (bit_cnt_ff == BITS_PER_BYTE);
  assign own_addr   = addr_strap ? ADDR_STRAP_HI : ADDR_STRAP_LO;
  assign addr_hit   = (shift_ff[7:1] == own_addr);

  // previous line levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // bit sampling on clock rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      nack_ff    <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bit_cnt_ff <= 4'h0;
    end else if (scl_rise) begin
      if (state_ff == SL_RACK) begin
        nack_ff <= sda_i;
      end else if (state_ff == SL_ADDR || state_ff == SL_WDATA || state_ff == SL_RDATA) begin
        shift_ff   <= {shift_ff[6:0], sda_i};
        bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
      end
    end else if (scl_fall && (state_ff == SL_ACK_ADDR || state_ff == SL_ACK_DATA
                              || state_ff == SL_RACK || byte_done)) begin
      bit_cnt_ff <= 4'h0;
    end
  end

  // slave sequence, data line changes on clock fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff  <= SL_IDLE;
      rw_ff     <= 1'b0;
      tx_ff     <= 8'h00;
      sda_oe_ff <= 1'b0;
    end else if (start_seen) begin
      state_ff  <= SL_ADDR;
      sda_oe_ff <= 1'b0;
    end else if (stop_seen) begin
      state_ff  <= SL_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_ff)
        SL_IDLE: ;
        SL_ADDR: if (byte_done) begin
          if (addr_hit) begin
            state_ff  <= SL_ACK_ADDR;
            rw_ff     <= shift_ff[0];
            sda_oe_ff <= 1'b1;
          end else begin
            state_ff <= SL_IDLE;
          end
        end
        SL_ACK_ADDR: begin
          if (rw_ff) begin
            state_ff  <= SL_RDATA;
            tx_ff     <= {ctrl_ff[6:0], 1'b0};
            sda_oe_ff <= ~ctrl_ff[7];
          end else begin
            state_ff  <= SL_WDATA;
            sda_oe_ff <= 1'b0;
          end
        end
        SL_WDATA: if (byte_done) begin
          state_ff  <= SL_ACK_DATA;
          sda_oe_ff <= 1'b1;
        end
        SL_ACK_DATA: begin
          state_ff  <= SL_WDATA;
          sda_oe_ff <= 1'b0;
        end
        SL_RDATA: begin
          if (byte_done) begin
            state_ff  <= SL_RACK;
            sda_oe_ff <= 1'b0;
          end else begin
            tx_ff     <= {tx_ff[6:0], 1'b0};
            sda_oe_ff <= ~tx_ff[7];
          end
        end
        SL_RACK: begin
          if (nack_ff) begin
            state_ff  <= SL_IDLE;
            sda_oe_ff <= 1'b0;
          end else begin
            state_ff  <= SL_RDATA;
            tx_ff     <= {ctrl_ff[6:0], 1'b0};
            sda_oe_ff <= ~ctrl_ff[7];
          end
        end
      endcase
    end
  end

  // level control register, written only in write mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (scl_fall && state_ff == SL_WDATA && byte_done) begin
      ctrl_ff <= shift_ff;
    end
  end

  // identical decoder per channel, outputs registered
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic            dec_en;
    logic            dec_rng;
    logic [1:0]      dec_step;
    logic [MV_W-1:0] dec_mv;
    logic            dec_bad;

    level_decode u_dec (
      .field      (ctrl_ff[ch*FIELD_W +: FIELD_W]),
      .enable     (dec_en),
      .range_high (dec_rng),
      .step       (dec_step),
      .nominal_mv (dec_mv),
      .illegal    (dec_bad)
    );

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        en_ff[ch]   <= 1'b0;
        rng_ff[ch]  <= 1'b0;
        bad_ff[ch]  <= 1'b0;
        step_ff[ch] <= 2'h0;
        mv_ff[ch]   <= '0;
      end else begin
        en_ff[ch]   <= dec_en;
        rng_ff[ch]  <= dec_rng;
        bad_ff[ch]  <= dec_bad;
        step_ff[ch] <= dec_step;
        mv_ff[ch]   <= dec_mv;
      end
    end
  end

  // sda_o is a flop held low: the line is open drain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe        = sda_oe_ff;
  assign level_control = ctrl_ff;
  assign supply_en_a   = en_ff[0];
  assign range_high_a  = rng_ff[0];
  assign level_step_a  = step_ff[0];
  assign nominal_mv_a  = mv_ff[0];
  assign code_bad_a    = bad_ff[0];
  assign supply_en_b   = en_ff[1];
  assign range_high_b  = rng_ff[1];
  assign level_step_b  = step_ff[1];
  assign nominal_mv_b  = mv_ff[1];
  assign code_bad_b    = bad_ff[1];

  // helper: has any write reached the register yet
  logic wr_seen_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_seen_ff <= 1'b0;
    end else if (scl_fall && state_ff == SL_WDATA && byte_done) begin
      wr_seen_ff <= 1'b1;
    end
  end

  // checks
  property p_range_msb;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_ff[3:0] == CODE_HI_2) ##1 $stable(ctrl_ff) |=> range_high_a && supply_en_a;
  endproperty
  a_range_msb: assert property (p_range_msb) else $error("range bit not followed");

  property p_standby;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_ff[7:4] == CODE_STANDBY) |=> !supply_en_b && nominal_mv_b == '0;
  endproperty
  a_standby: assert property (p_standby) else $error("zero code left output on");

  property p_levels_on;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_ff[3:0] == CODE_LO_1) |=> supply_en_a && !range_high_a && level_step_a == 2'h1;
  endproperty
  a_levels_on: assert property (p_levels_on) else $error("legal code not enabled");

  property p_volt_map;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_ff[7:4] == CODE_HI_3) |=> nominal_mv_b == MV_HI_3 && level_step_b == 2'h3;
  endproperty
  a_volt_map: assert property (p_volt_map) else $error("voltage map wrong");

  property p_same_map;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_ff[3:0] == ctrl_ff[7:4]) |=> nominal_mv_a == nominal_mv_b
        && supply_en_a == supply_en_b && level_step_a == level_step_b;
  endproperty
  a_same_map: assert property (p_same_map) else $error("channels decode differently");

  property p_addr_ack;
    @(posedge clk) disable iff (!arst_n)
      (state_ff == SL_ADDR && scl_fall && byte_done && !start_seen && !stop_seen)
        |=> sda_oe == (shift_ff[7:1] == (addr_strap ? 7'h09 : 7'h08));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address answer wrong");

  property p_read_no_write;
    @(posedge clk) disable iff (!arst_n)
      (state_ff == SL_RDATA || state_ff == SL_RACK) |=> $stable(ctrl_ff);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read altered register");

  property p_reset_standby;
    @(posedge clk) disable iff (!arst_n)
      !wr_seen_ff |-> ctrl_ff == 8'h00 && !supply_en_a && !supply_en_b;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("not standby after reset");

  c_write: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == SL_ACK_DATA ##1 state_ff == SL_WDATA);
  c_read: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == SL_RACK && scl_fall && !nack_ff);
  c_to_standby: cover property (@(posedge clk) disable iff (!arst_n)
    supply_en_a ##1 !supply_en_a);
endmodule

/* level_decode.sv */
`timescale 1ns/100ps
module level_decode
  import level_select_pkg::*;
(
  input  wire logic [level_select_pkg::FIELD_W-1:0] field,      // level select field
  output logic                                      enable,     // supply output on
  output logic                                      range_high, // 18 V range
  output logic [1:0]                                step,       // level within range
  output logic [level_select_pkg::MV_W-1:0]         nominal_mv, // nominal millivolts
  output logic                                      illegal     // unlisted code
);
  // each channel gets its own instance of this decoder, so the mapping is identical
  always_comb begin
    enable     = 1'b1;
    range_high = field[RANGE_BIT];
    step       = field[1:0];
    nominal_mv = '0;
    illegal    = 1'b0;
    unique case (field)
      CODE_STANDBY: begin
        enable = 1'b0;
        step   = 2'h0;
      end
      CODE_LO_0: nominal_mv = MV_LO_0;
      CODE_LO_1: nominal_mv = MV_LO_1;
      CODE_LO_2: nominal_mv = MV_LO_2;
      CODE_LO_3: begin
        nominal_mv = MV_LO_3;
        step       = 2'h3;
      end
      CODE_HI_0: nominal_mv = MV_HI_0;
      CODE_HI_1: nominal_mv = MV_HI_1;
      CODE_HI_2: nominal_mv = MV_HI_2;
      CODE_HI_3: nominal_mv = MV_HI_3;
      default: begin
        // unlisted codes keep the output off
        enable     = 1'b0;
        range_high = 1'b0;
        step       = 2'h0;
        illegal    = 1'b1;
      end
    endcase
    if (field == CODE_LO_0 || field == CODE_LO_1 || field == CODE_LO_2) begin
      step = 2'(field[1:0] - 2'h1);
    end
  end
endmodule

/* level_select_pkg.sv */
package level_select_pkg;

  // field geometry of the level control register
  localparam int          FIELD_W       = 4;
  localparam int          CHANNELS      = 2;
  localparam int          CTRL_W        = FIELD_W * CHANNELS;
  localparam int          RANGE_BIT     = 3;
  localparam int          MV_W          = 16;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // serial slave addresses selected by the strap
  localparam logic [6:0]  ADDR_STRAP_LO = 7'h08;
  localparam logic [6:0]  ADDR_STRAP_HI = 7'h09;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // legal level codes
  localparam logic [3:0]  CODE_STANDBY  = 4'h0;
  localparam logic [3:0]  CODE_LO_0     = 4'h1;
  localparam logic [3:0]  CODE_LO_1     = 4'h2;
  localparam logic [3:0]  CODE_LO_2     = 4'h3;
  localparam logic [3:0]  CODE_LO_3     = 4'h4;
  localparam logic [3:0]  CODE_HI_0     = 4'h8;
  localparam logic [3:0]  CODE_HI_1     = 4'h9;
  localparam logic [3:0]  CODE_HI_2     = 4'ha;
  localparam logic [3:0]  CODE_HI_3     = 4'hb;

  // nominal output voltage in millivolts
  localparam logic [15:0] MV_LO_0       = 16'h32c8; // 13000
  localparam logic [15:0] MV_LO_1       = 16'h3415; // 13333
  localparam logic [15:0] MV_LO_2       = 16'h3563; // 13667
  localparam logic [15:0] MV_LO_3       = 16'h36b0; // 14000
  localparam logic [15:0] MV_HI_0       = 16'h46e6; // 18150
  localparam logic [15:0] MV_HI_1       = 16'h4833; // 18483
  localparam logic [15:0] MV_HI_2       = 16'h4981; // 18817
  localparam logic [15:0] MV_HI_3       = 16'h4ace; // 19150

  // serial slave states
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_ADDR,
    SL_ACK_ADDR,
    SL_WDATA,
    SL_ACK_DATA,
    SL_RDATA,
    SL_RACK
  } slave_state_t;

endpackage

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
  import level_select_pkg::*;
  typedef struct packed {
    logic [3:0]  code;
    logic        en;
    logic        hi;
    logic [1:0]  step;
    logic [15:0] mv;
    logic        bad;
  } row_t;

  logic        clk, arst_n, addr_strap, scl, sda_low, sda_line, sda_o, sda_oe, ack_n;
  logic [7:0]  level_control, rd;
  logic        supply_en_a, range_high_a, code_bad_a, supply_en_b, range_high_b, code_bad_b;
  logic [1:0]  level_step_a, level_step_b;
  logic [15:0] nominal_mv_a, nominal_mv_b;
  int          bad_count = 0;
  int          cmp_count = 0;

  // one row per field code: expected decode of that code
  row_t rows [16] = '{
    '{4'h0, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h0}, '{4'h1, 1'h1, 1'h0, 2'h0, 16'h32c8, 1'h0},
    '{4'h2, 1'h1, 1'h0, 2'h1, 16'h3415, 1'h0}, '{4'h3, 1'h1, 1'h0, 2'h2, 16'h3563, 1'h0},
    '{4'h4, 1'h1, 1'h0, 2'h3, 16'h36b0, 1'h0}, '{4'h5, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1},
    '{4'h6, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1}, '{4'h7, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1},
    '{4'h8, 1'h1, 1'h1, 2'h0, 16'h46e6, 1'h0}, '{4'h9, 1'h1, 1'h1, 2'h1, 16'h4833, 1'h0},
    '{4'ha, 1'h1, 1'h1, 2'h2, 16'h4981, 1'h0}, '{4'hb, 1'h1, 1'h1, 2'h3, 16'h4ace, 1'h0},
    '{4'hc, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1}, '{4'hd, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1},
    '{4'he, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1}, '{4'hf, 1'h0, 1'h0, 2'h0, 16'h0000, 1'h1}};

  // open-drain data wire with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

  always #4 clk = ~clk;

  bus_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  dual_supply_level_select DUT (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .level_control(level_control),
    .supply_en_a(supply_en_a), .range_high_a(range_high_a), .level_step_a(level_step_a),
    .nominal_mv_a(nominal_mv_a), .code_bad_a(code_bad_a), .supply_en_b(supply_en_b),
    .range_high_b(range_high_b), .level_step_b(level_step_b),
    .nominal_mv_b(nominal_mv_b), .code_bad_b(code_bad_b));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one channel's decoded outputs against a row; range and step only when on
  task automatic check_chan(input logic en, hi, input logic [1:0] stp,
                            input logic [15:0] mv, input logic bad, input row_t r);
    check(en, r.en);
    check(mv, r.mv);
    check(bad, r.bad);
    if (r.en) begin
      check(hi, r.hi);
      check(stp, r.step);
    end
  endtask

  // write one data byte; data only sent when the address was answered
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic exp_nack);
    host.bus_start();
    host.send_byte({a, 1'h0}, ack_n);
    check(ack_n, exp_nack);
    if (!ack_n) host.send_byte(d, ack_n);
    host.bus_stop();
    repeat (4) @(negedge clk);
  endtask

  task automatic check_both(input int ia, input int ib);
    check_chan(supply_en_a, range_high_a, level_step_a, nominal_mv_a, code_bad_a, rows[ia]);
    check_chan(supply_en_b, range_high_b, level_step_b, nominal_mv_b, code_bad_b, rows[ib]);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog well beyond the expected run of about 5200 clocks
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    clk        = 1'h0;
    arst_n     = 1'h0;
    addr_strap = 1'h0;
    repeat (16) @(negedge clk);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
    check(level_control, CTRL_RESET);
    check_both(0, 0);
    // every code on both channels, opposite order on channel b
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_STRAP_LO, {rows[15-i].code, rows[i].code}, 1'h0);
      check(level_control, {rows[15-i].code, rows[i].code});
      check_both(i, 15 - i);
    end
    // other address ignored, register kept; after the strap moves, the high address writes
    wr(ADDR_STRAP_HI, 8'h91, 1'h1);
    check(level_control, 8'h0f);
    addr_strap = 1'h1;
    wr(ADDR_STRAP_LO, 8'h91, 1'h1);
    check(level_control, 8'h0f);
    wr(ADDR_STRAP_HI, 8'h91, 1'h0);
    check(level_control, 8'h91);
    // read with ack then nack, register returned both times
    host.bus_start();
    host.send_byte({ADDR_STRAP_HI, 1'h1}, ack_n);
    check(ack_n, 1'h0);
    host.recv_byte(1'h1, rd);
    check(rd, 8'h91);
    host.recv_byte(1'h0, rd);
    check(rd, 8'h91);
    host.bus_stop();
    check(level_control, 8'h91);
    check(sda_o, 1'h0);
    // two data bytes in one write, last one stays
    host.bus_start();
    host.send_byte({ADDR_STRAP_HI, 1'h0}, ack_n);
    host.send_byte(8'h48, ack_n);
    host.send_byte(8'hb1, ack_n);
    host.bus_stop();
    repeat (4) @(negedge clk);
    check(level_control, 8'hb1);
    check_both(1, 11);
    // reset in mid-run returns both channels to standby
    arst_n = 1'h0;
    @(negedge clk);
    check(level_control, CTRL_RESET);
    check_both(0, 0);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
    complete_run();
  end
endmodule
